// ### acrc_host.sv
// Purpose: host end: drives start/read strobes in four modes, buffers results
// Assumes: pins synchronous to clk
// Notes:   results leave through a 16-word FIFO
`timescale 1ns/100ps
module acrc_host
  import acrc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // user control
  input  wire acrc_mode_t        mode,
  input  wire logic              sample_req,
  input  wire logic              power_down_req,
  input  wire logic              deep_req,
  // result stream
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic [DATA_W-1:0]      res_data,
  // pins
  acrc_if.host                   pins
);

  typedef enum logic [2:0] {
    ACRC_H_IDLE,
    ACRC_H_STROBE,
    ACRC_H_WAIT,
    ACRC_H_READ,
    ACRC_H_GAP,
    ACRC_H_SETTLE
  } acrc_host_state_t;

  acrc_host_state_t  state;
  logic [23:0]       cnt;
  logic              busy_q;
  logic              busy_rise;
  logic              fifo_ready;
  logic              push;
  logic [DATA_W-1:0] push_data;
  logic              strobe;
  logic              rd;
  logic              down;

  assign busy_rise = ~busy_q & pins.busy_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= pins.busy_n;
    end
  end

  // ****************************************
  // strobe sequencing
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ACRC_H_IDLE;
      cnt       <= '0;
      strobe    <= 1'b0;
      rd        <= 1'b0;
      down      <= 1'b0;
      push      <= 1'b0;
      push_data <= RESULT_RST;
    end else begin
      push <= 1'b0;
      case (state)
        ACRC_H_IDLE: begin
          rd   <= 1'b0;
          down <= power_down_req;
          if (power_down_req) begin
            state <= ACRC_H_SETTLE;
          end else if (sample_req && fifo_ready) begin
            strobe <= 1'b1;
            state  <= ACRC_H_STROBE;
          end
        end
        ACRC_H_STROBE: begin
          if (mode == ACRC_MODE_ROM) begin
            strobe    <= 1'b0;
            push      <= 1'b1;
            push_data <= pins.data_out;
            state     <= ACRC_H_WAIT;
          end else if (mode != ACRC_MODE_SLOW_MEM) begin
            strobe <= 1'b0;
            state  <= ACRC_H_WAIT;
          end else begin
            state <= ACRC_H_WAIT;
          end
        end
        ACRC_H_WAIT: begin
          // bus idle while converting in strobed and ROM modes
          if (busy_rise) begin
            strobe <= 1'b0;
            if (mode == ACRC_MODE_STROBED) begin
              rd    <= 1'b1;
              state <= ACRC_H_READ;
            end else begin
              if (mode != ACRC_MODE_ROM) begin
                push      <= 1'b1;
                push_data <= pins.data_out;
              end
              cnt   <= 24'(ACQ_CYC);
              state <= ACRC_H_GAP;
            end
          end
        end
        ACRC_H_READ: begin
          rd        <= 1'b0;
          push      <= 1'b1;
          push_data <= pins.data_out;
          cnt       <= 24'(ACQ_CYC);
          state     <= ACRC_H_GAP;
        end
        ACRC_H_GAP: begin
          if (cnt == 24'h00_0000) begin
            state <= ACRC_H_IDLE;
          end else begin
            cnt <= cnt - 24'h00_0001;
          end
        end
        ACRC_H_SETTLE: begin
          if (power_down_req) begin
            cnt <= deep_req ? 24'(SLEEP_WAKE_CYC) : 24'(NAP_WAKE_CYC);
          end else if (cnt == 24'h00_0000) begin
            down  <= 1'b0;
            state <= ACRC_H_IDLE;
          end else begin
            down <= 1'b0;
            cnt  <= cnt - 24'h00_0001;
          end
        end
        default: begin
          state <= ACRC_H_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  always_comb begin
    pins.chip_select_n         = 1'b0;
    pins.conversion_start_n    = ~strobe;
    pins.power_down_n          = ~down;
    pins.shutdown_depth_select = ~deep_req;
    case (mode)
      ACRC_MODE_ALWAYS:   pins.read_n = 1'b0;
      ACRC_MODE_STROBED:  pins.read_n = ~rd;
      ACRC_MODE_SLOW_MEM: pins.read_n = ~strobe;
      ACRC_MODE_ROM:      pins.read_n = ~strobe;
      default:            pins.read_n = 1'b1;
    endcase
  end

  // ****************************************
  // result buffer
  // ****************************************
  acrc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

endmodule // acrc_host

// ### acrc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 25 MHz system clock
// Notes:   timing counts derived from printed times
package acrc_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned DATA_W          = 12;
  localparam int unsigned CONV_TYP_NS     = 650;
  localparam int unsigned CONV_MAX_NS     = 750;
  localparam int unsigned ACQ_MIN_NS      = 100;
  localparam int unsigned THRU_NS         = 800;
  localparam int unsigned NAP_WAKE_NS     = 200;
  localparam int unsigned SLEEP_WAKE_MS   = 10;
  localparam int unsigned FIFO_DEPTH      = 16;

  // typical times round down, least times round up
  localparam int unsigned CONV_CYC      = CONV_TYP_NS / CLK_PERIOD_NS;
  localparam int unsigned ACQ_CYC       = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NAP_WAKE_CYC  = NAP_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_WAKE_CYC = (SLEEP_WAKE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [4:0] CONV_CNT_W     = 5'h10;
  localparam logic [DATA_W-1:0] RESULT_RST = 12'h000;

  typedef enum logic [1:0] {
    ACRC_MODE_ALWAYS,
    ACRC_MODE_STROBED,
    ACRC_MODE_SLOW_MEM,
    ACRC_MODE_ROM
  } acrc_mode_t;

endpackage

// ### acrc_if.sv
// Purpose: pins between converter and host
// Assumes: one clock, pins synchronous
// Notes:   data pins carried as out/enable
`timescale 1ns/100ps
interface acrc_if;
  logic              chip_select_n;
  logic              read_n;
  logic              conversion_start_n;
  logic              power_down_n;
  logic              shutdown_depth_select;
  logic              busy_n;
  logic [11:0]       data_out;
  logic              data_oe;

  modport device (
    input  chip_select_n,
    input  read_n,
    input  conversion_start_n,
    input  power_down_n,
    input  shutdown_depth_select,
    output busy_n,
    output data_out,
    output data_oe
  );

  modport host (
    output chip_select_n,
    output read_n,
    output conversion_start_n,
    output power_down_n,
    output shutdown_depth_select,
    input  busy_n,
    input  data_out,
    input  data_oe
  );
endinterface

// ### acrc_fifo.sv
// Purpose: result buffer on host side
// Assumes: single clock
// Notes:   valid/ready both sides
`timescale 1ns/100ps
module acrc_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // acrc_fifo

// ### acrc_device.sv
// Purpose: converter end: start, busy, result output, shutdown
// Assumes: pins synchronous to clk; sample comes from a user port
// Notes:   user side supplies the analog-equivalent sample word
`timescale 1ns/100ps
module acrc_device
  import acrc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // user side
  input  wire logic [DATA_W-1:0] sample_in,
  output logic                   powered,
  output logic                   deep_sleep,
  // pins
  acrc_if.device                 pins
);

  typedef enum logic [1:0] {
    ACRC_IDLE,
    ACRC_CONV,
    ACRC_WAKE,
    ACRC_DOWN
  } acrc_dev_state_t;

  acrc_dev_state_t   state;
  logic [4:0]        conv_cnt;
  logic [23:0]       wake_cnt;
  logic              start_q;
  logic              start_fall;
  logic [DATA_W-1:0] held_sample;
  logic [DATA_W-1:0] result;

  // ****************************************
  // start detection
  // ****************************************
  assign start_fall = start_q & ~pins.conversion_start_n & ~pins.chip_select_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b1;
    end else begin
      start_q <= pins.conversion_start_n;
    end
  end

  // ****************************************
  // conversion and shutdown sequencing
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ACRC_IDLE;
      conv_cnt <= '0;
      wake_cnt <= '0;
    end else begin
      case (state)
        ACRC_IDLE: begin
          if (!pins.power_down_n) begin
            state <= ACRC_DOWN;
          end else if (start_fall) begin
            state    <= ACRC_CONV;
            conv_cnt <= 5'(CONV_CYC - 1);
          end
        end
        ACRC_CONV: begin
          // starts ignored here
          if (conv_cnt == 5'h00) begin
            state <= ACRC_IDLE;
          end else begin
            conv_cnt <= conv_cnt - 5'h01;
          end
        end
        ACRC_DOWN: begin
          if (pins.power_down_n) begin
            state    <= ACRC_WAKE;
            wake_cnt <= deep_sleep ? 24'(SLEEP_WAKE_CYC - 1) : 24'(NAP_WAKE_CYC - 1);
          end
        end
        ACRC_WAKE: begin
          if (!pins.power_down_n) begin
            state <= ACRC_DOWN;
          end else if (wake_cnt == 24'h00_0000) begin
            state <= ACRC_IDLE;
          end else begin
            wake_cnt <= wake_cnt - 24'h00_0001;
          end
        end
        default: begin
          state <= ACRC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      deep_sleep <= 1'b0;
    end else if (state != ACRC_DOWN && !pins.power_down_n) begin
      deep_sleep <= ~pins.shutdown_depth_select;
    end
  end

  // ****************************************
  // sample hold and result
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_sample <= RESULT_RST;
      result      <= RESULT_RST;
    end else begin
      if (state == ACRC_IDLE && start_fall) begin
        held_sample <= sample_in;
      end
      if (state == ACRC_CONV && conv_cnt == 5'h00) begin
        result <= held_sample;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pins.busy_n   = (state != ACRC_CONV);
  assign pins.data_out = result;
  assign pins.data_oe  = ~pins.chip_select_n & ~pins.read_n;
  assign powered       = (state == ACRC_IDLE) | (state == ACRC_CONV);

endmodule // acrc_device

// ### acrc_checker.sv
// Purpose: pin checks between converter and host
// Assumes: one clock, async low reset
// Notes:   plain inputs, instanced beside the interface
`timescale 1ns/100ps
module acrc_checker
  import acrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // pins
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic        conversion_start_n,
  input  wire logic        power_down_n,
  input  wire logic        shutdown_depth_select,
  input  wire logic        busy_n,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe
);
  // ****
  // busy length counter
  // ****
  logic [7:0] low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 8'h00;
    end else if (busy_n) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  // ****
  // properties
  // ****
  property p_start;
    $fell(conversion_start_n) && !chip_select_n && busy_n && power_down_n && $past(power_down_n, 8) |=> !busy_n;
  endproperty
  property p_len;
    $rose(busy_n) |-> low_cnt == 8'(CONV_CYC);
  endproperty
  property p_max;
    low_cnt <= 8'(CONV_MAX_NS / CLK_PERIOD_NS);
  endproperty
  property p_keep;
    !busy_n |-> $stable(data_out);
  endproperty
  property p_upd;
    $changed(data_out) |-> $rose(busy_n);
  endproperty
  property p_oe;
    data_oe == (!chip_select_n && !read_n);
  endproperty
  property p_power_down_n;
    !power_down_n && busy_n |=> busy_n;
  endproperty
  property p_gap;
    $fell(conversion_start_n) |-> $past(busy_n, 1) && $past(busy_n, 2) && $past(busy_n, 3);
  endproperty
  property p_wait;
    !conversion_start_n && !busy_n |=> !conversion_start_n || busy_n;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  a_len: assert property (p_len) else $error("busy length wrong");
  a_max: assert property (p_max) else $error("conversion too long");
  a_keep: assert property (p_keep) else $error("result moved while busy");
  a_upd: assert property (p_upd) else $error("result moved off busy rise");
  a_oe: assert property (p_oe) else $error("data enable wrong");
  a_power_down_n: assert property (p_power_down_n) else $error("started in shutdown");
  a_gap: assert property (p_gap) else $error("acquisition gap short");
  a_wait: assert property (p_wait) else $error("strobe released early");
  c_conv: cover property ($rose(busy_n));
  c_read: cover property ($rose(data_oe));
  c_nap: cover property ($fell(power_down_n) && shutdown_depth_select);
  c_sleep: cover property ($fell(power_down_n) && !shutdown_depth_select);
endmodule // acrc_checker

// ### acrc_tb_top.sv
// Purpose: both ends joined, all modes exercised
// Assumes: 25 MHz clock
// Notes:   deep wake too long to run, deep entry only
`timescale 1ns/100ps
module acrc_tb_top
  import acrc_pkg::*;
;
  logic              clk;
  logic              arst_n;
  logic [11:0]       sample_in;
  logic              powered;
  logic              deep_sleep;
  acrc_mode_t        mode;
  logic              sample_req;
  logic              power_down_req;
  logic              deep_req;
  logic              res_valid;
  logic              res_ready;
  logic [11:0]       res_data;
  int                miscompares;
  int                n_tests;
  acrc_if acrc_if_i ();
  acrc_device acrc_device_i (.clk(clk), .arst_n(arst_n), .sample_in(sample_in), .powered(powered),
    .deep_sleep(deep_sleep), .pins(acrc_if_i));
  acrc_host acrc_host_i (.clk(clk), .arst_n(arst_n), .mode(mode), .sample_req(sample_req),
    .power_down_req(power_down_req), .deep_req(deep_req), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .pins(acrc_if_i));
  acrc_checker acrc_checker_i (.clk(clk), .arst_n(arst_n), .chip_select_n(acrc_if_i.chip_select_n),
    .read_n(acrc_if_i.read_n), .conversion_start_n(acrc_if_i.conversion_start_n),
    .power_down_n(acrc_if_i.power_down_n), .shutdown_depth_select(acrc_if_i.shutdown_depth_select),
    .busy_n(acrc_if_i.busy_n), .data_out(acrc_if_i.data_out), .data_oe(acrc_if_i.data_oe));
  // ****
  // shared tasks
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic pop();
    res_ready = 1'b1;
    @(negedge clk);
    res_ready = 1'b0;
  endtask
  task automatic conv(input acrc_mode_t m, input logic [11:0] s, input logic [11:0] exp);
    int i;
    mode = m;
    sample_in = s;
    sample_req = 1'b1;
    @(negedge clk);
    sample_req = 1'b0;
    for (i = 0; i < 300 && res_valid !== 1'b1; i++) @(negedge clk);
    if (res_valid !== 1'b1) begin
      miscompares++;
      stop_test();
    end
    check("res_data", res_data, exp);
    pop();
    repeat (25) @(negedge clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_modes();
    conv(ACRC_MODE_ALWAYS, 12'h7ff, 12'h7ff);
    conv(ACRC_MODE_ALWAYS, 12'h800, 12'h800);
    check("data_oe", 12'(acrc_if_i.data_oe), 12'h001);
    conv(ACRC_MODE_STROBED, 12'h123, 12'h123);
    check("data_oe", 12'(acrc_if_i.data_oe), 12'h000);
    conv(ACRC_MODE_SLOW_MEM, 12'h456, 12'h456);
    conv(ACRC_MODE_ROM, 12'h9ab, 12'h456);
    conv(ACRC_MODE_ROM, 12'h000, 12'h9ab);
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    mode = ACRC_MODE_ALWAYS;
    sample_in = 12'h0f0;
    sample_req = 1'b1;
    repeat (500) @(negedge clk);
    sample_req = 1'b0;
    repeat (30) @(negedge clk);
    while (res_valid === 1'b1 && n < 20) begin
      check("fill_data", res_data, 12'h0f0);
      pop();
      n++;
    end
    check("fill_count", 12'(n), 12'(FIFO_DEPTH));
    check("res_valid", 12'(res_valid), 12'h000);
  endtask
  task automatic t_power();
    deep_req = 1'b1;
    @(negedge clk);
    check("depth_select", 12'(acrc_if_i.shutdown_depth_select), 12'h000);
    deep_req = 1'b0;
    power_down_req = 1'b1;
    repeat (5) @(negedge clk);
    check("power_down_n", 12'(acrc_if_i.power_down_n), 12'h000);
    check("powered", 12'(powered), 12'h000);
    check("deep_sleep", 12'(deep_sleep), 12'h000);
    power_down_req = 1'b0;
    repeat (8) @(negedge clk);
    check("powered", 12'(powered), 12'h001);
    conv(ACRC_MODE_ALWAYS, 12'h321, 12'h321);
    deep_req = 1'b1;
    power_down_req = 1'b1;
    repeat (5) @(negedge clk);
    check("deep_sleep", 12'(deep_sleep), 12'h001);
    check("powered", 12'(powered), 12'h000);
  endtask
  initial begin
    arst_n = 1'b0;
    sample_in = 12'h000;
    mode = ACRC_MODE_ALWAYS;
    sample_req = 1'b0;
    power_down_req = 1'b0;
    deep_req = 1'b0;
    res_ready = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_modes();
    t_fill();
    t_power();
    stop_test();
  end
endmodule // acrc_tb_top
